// file: bench/brk_fail_props.sv
// Port checker for the breaker-failure timer, bound to the timer
`timescale 1ns/1ns
`default_nettype none
module brk_fail_props (
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic                 trip_mon_i,
  input wire logic                 dig_in_i,
  input wire logic                 block_i,
  input wire brk_fail_pkg::cfg_t   cfg_i,
  input wire logic                 start_o,
  input wire logic                 retrip_o,
  input wire logic                 breaker_fail_output_o,
  input wire logic                 blocked_o,
  input wire brk_fail_pkg::event_t event_o,
  input wire logic [brk_fail_pkg::NUM_OPCNT-1:0][brk_fail_pkg::CNT_W-1:0]
                                   op_cnt_o,
  input wire logic [brk_fail_pkg::LOG_IDX_W-1:0] log_count_o
);
  import brk_fail_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Or mode pick-up held by the trip contact alone, unblocked
  sequence or_hold;
    cfg_i.mode == CRIT_CUR_OR_OUT && trip_mon_i && !block_i && !blocked_o;
  endsequence

  a_block_excl: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  a_block_drop: assert property (block_i && start_o |-> ##2 !start_o)
    else $error("block did not release start");
  a_fail_start: assert property (breaker_fail_output_o |-> start_o)
    else $error("fail without start");
  a_retrip_en: assert property (retrip_o |-> $past(cfg_i.retrip_en))
    else $error("retrip while disabled");
  a_and_hold: assert property (
    cfg_i.mode == CRIT_CUR_AND_OUT && !trip_mon_i
    |-> ##2 !breaker_fail_output_o) else $error("and mode ran alone");
  a_or_pick: assert property (or_hold [*3] |-> start_o)
    else $error("or mode trip did not start");
  a_input_clr: assert property (
    cfg_i.mode == CRIT_INPUT && !dig_in_i |-> ##2 !start_o)
    else $error("input mode ran without input");
  a_ev_off: assert property (
    $past(cfg_i.ev_sel) == SEL_OFF && cfg_i.ev_sel == SEL_OFF
    |-> event_o.on == 8'h00) else $error("on event passed filter");
  a_log_cap: assert property (log_count_o <= 4'hC)
    else $error("log count over depth");
  a_cnt_step: assert property (
    $changed(op_cnt_o[K_START]) |-> op_cnt_o[K_START] <= 16'h0001 ||
    op_cnt_o[K_START] == $past(op_cnt_o[K_START]) + 16'h0001)
    else $error("start counter jumped");
endmodule // brk_fail_props

bind brk_fail_timer brk_fail_props u_props (
  .clk_sys_i, .rst_n_i, .trip_mon_i, .dig_in_i, .block_i, .cfg_i,
  .start_o, .retrip_o, .breaker_fail_output_o, .blocked_o,
  .event_o, .op_cnt_o, .log_count_o
);
`default_nettype wire

// file: bench/brk_trip_model.sv
// Primary protection stage model: trip contact follows its command late
`timescale 1ns/1ns
`default_nettype none
module brk_trip_model #(
  parameter int unsigned LAT = 3
) (
  input  wire logic clk_sys_i,
  input  wire logic cmd_i,
  output logic      trip_mon_o
);
  logic [LAT-1:0] pipe_ff = '0;

  // Contact closes and opens LAT cycles after the stage decides
  always @(posedge clk_sys_i) begin
    pipe_ff <= {pipe_ff[LAT-2:0], cmd_i};
  end
  assign trip_mon_o = pipe_ff[LAT-1];
endmodule // brk_trip_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking testbench of the breaker-failure timer
`timescale 1ns/1ns
`default_nettype none
module tb;
  import brk_fail_pkg::*;
  localparam int STEP = 4;
  localparam meas_t OVER = '{16'h0064, 16'h012C, 16'h00C8, 16'h0000};
  typedef struct packed {
    crit_mode_t m;
    logic [4:0] v; // Over, trip, input, retrip enable, fail expected
  } row_t;
  localparam row_t ROWS [9] = '{
    '{CRIT_CURRENT, 5'h13}, '{CRIT_CURRENT, 5'h0A}, '{CRIT_CURRENT, 5'h11},
    '{CRIT_CUR_AND_OUT, 5'h12}, '{CRIT_CUR_AND_OUT, 5'h1B},
    '{CRIT_CUR_OR_OUT, 5'h0B}, '{CRIT_CUR_OR_OUT, 5'h13},
    '{CRIT_INPUT, 5'h07}, '{CRIT_INPUT, 5'h1A}};
  logic clk_sys_i, rst_n_i, ce_i, trip_mon_i, dig_in_i, block_i, cmd;
  logic start_o, retrip_o, breaker_fail_output_o, blocked_o;
  logic [CUR_W-1:0]     ph_set_i, res_set_i;
  logic [GRP_W-1:0]     group_i;
  logic [TS_W-1:0]      stamp_i = '0;
  logic [3:0]           cnt_clr_i, log_idx_i, log_count_o;
  logic [DLY_W-1:0]     retrip_time_remaining_o, fail_time_remaining_o;
  logic [3:0][CNT_W-1:0] op_cnt_o;
  meas_t                meas_i;
  cfg_t                 cfg_i;
  event_t               event_o;
  log_rec_t             log_rec_o, newest;
  logic [1:0]           seen;
  int                   fail_count, samples_checked, nr, nf;

  brk_fail_timer #(.STEP_CYCLES(STEP)) u_brk_fail_timer (
    .clk_sys_i, .rst_n_i, .ce_i, .meas_i, .ph_set_i, .res_set_i,
    .trip_mon_i, .dig_in_i, .block_i, .cfg_i, .group_i, .stamp_i,
    .cnt_clr_i, .log_idx_i, .start_o, .retrip_o, .breaker_fail_output_o,
    .blocked_o, .retrip_time_remaining_o, .fail_time_remaining_o,
    .event_o, .op_cnt_o, .log_rec_o, .log_count_o);
  brk_trip_model #(.LAT(3)) u_brk_trip_model (
    .clk_sys_i, .cmd_i(cmd), .trip_mon_o(trip_mon_i));

  // ----------------------------------------------------------------
  // Clock, time stamp and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) stamp_i <= stamp_i + 32'h00000001;

  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic put(input crit_mode_t m, input logic [3:0] v);
    @(posedge clk_sys_i);
    cfg_i.mode <= m;
    meas_i <= v[3] ? OVER : '0;
    cmd <= v[2];
    dig_in_i <= v[1];
    cfg_i.retrip_en <= v[0];
    #1;
  endtask
  task automatic rd_log(input logic [3:0] i);
    @(posedge clk_sys_i);
    log_idx_i <= i;
    repeat (2) tick();
  endtask
  task automatic rst_chk();
    chk({start_o, retrip_o, breaker_fail_output_o, blocked_o} === 4'h0
        && log_count_o === 4'h0 && op_cnt_o === '0, "reset state");
    chk(retrip_time_remaining_o === RETRIP_DLY_DEF
        && fail_time_remaining_o === FAIL_DLY_DEF, "reset remaining");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, dig_in_i, block_i, cmd, cnt_clr_i, log_idx_i} = '0;
    {ce_i, meas_i, group_i} = {1'h1, 64'h0, 3'h5};
    {ph_set_i, res_set_i} = {16'h0050, 16'h0100};
    cfg_i = '{CRIT_CURRENT, 1'h1, 1'h0, 1'h0, 19'h00001, 19'h00003,
              SEL_BOTH};
    fail_count = 0;
    samples_checked = 0;
    repeat (7) @(posedge clk_sys_i);
    #1;
    rst_chk();
    @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    foreach (ROWS[i]) begin
      put(ROWS[i].m, ROWS[i].v[4:1]);
      repeat (40) tick();
      chk(breaker_fail_output_o === ROWS[i].v[0], "fail");
      chk(retrip_o === (ROWS[i].v[0] & ROWS[i].v[1]), "rt");
      put(ROWS[i].m, {3'h0, ROWS[i].v[1]});
      repeat (8) tick();
      chk({start_o, breaker_fail_output_o} === 2'h0, "clr");
    end
    // One leg of the pick-up dropped: and mode clears, or mode holds
    for (int k = 1; k <= 2; k++) begin
      put(crit_mode_t'(k), 4'hD);
      repeat (8) tick();
      put(crit_mode_t'(k), 4'h9);
      repeat (8) tick();
      chk(start_o === (k == 2), "one leg dropped");
      put(crit_mode_t'(k), 4'h1);
      repeat (8) tick();
    end
    // Event filter codes on block input edges
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_sys_i);
      cfg_i.ev_sel <= ev_sel_t'(s);
      seen = 2'h0;
      @(posedge clk_sys_i);
      block_i <= 1'h1;
      repeat (4) begin tick(); seen[1] |= event_o.on[C_BLOCK]; end
      @(posedge clk_sys_i);
      block_i <= 1'h0;
      repeat (4) begin tick(); seen[0] |= event_o.off[C_BLOCK]; end
      chk(seen === {s != 1, s != 0}, "event filter");
    end
    // Delay timing after counter clear, then counters and log
    @(posedge clk_sys_i);
    cnt_clr_i <= 4'hF;
    @(posedge clk_sys_i);
    cnt_clr_i <= 4'h0;
    put(CRIT_CURRENT, 4'h9);
    {nr, nf} = {-32'sd1, -32'sd1};
    for (int n = 1; n <= 40; n++) begin
      tick();
      if (n == 3)
        chk(start_o === 1'h1 && retrip_time_remaining_o === 19'h00001
            && fail_time_remaining_o === 19'h00003, "remaining");
      if (retrip_o === 1'h1 && nr < 0) nr = n;
      if (breaker_fail_output_o === 1'h1 && nf < 0) nf = n;
    end
    chk(nr >= STEP && nr <= STEP + 4, "retrip delay");
    chk(nf >= 3 * STEP && nf <= 3 * STEP + 4, "fail delay");
    chk(op_cnt_o[K_START] === 16'h0001 && op_cnt_o[K_FAIL] === 16'h0001
        && op_cnt_o[K_RETRIP] === 16'h0001, "counters");
    chk(log_count_o === 4'hC, "log depth");
    rd_log(4'hB);
    newest = log_rec_o;
    chk(newest.ev === LOG_FAIL && newest.max_ph === 16'h012C, "new");
    chk(newest.group === 3'h5 && newest.retrip_left === '0, "rec");
    rd_log(4'h0);
    chk(log_rec_o.stamp < newest.stamp, "oldest first");
    // Block at pick-up, then block during timing
    put(CRIT_CURRENT, 4'h1);
    @(posedge clk_sys_i);
    block_i <= 1'h1;
    put(CRIT_CURRENT, 4'h9);
    repeat (4) tick();
    chk(blocked_o === 1'h1 && start_o === 1'h0, "blocked");
    put(CRIT_CURRENT, 4'h1);
    @(posedge clk_sys_i);
    block_i <= 1'h0;
    put(CRIT_CURRENT, 4'h9);
    repeat (4) tick();
    @(posedge clk_sys_i);
    block_i <= 1'h1;
    repeat (3) tick();
    chk(start_o === 1'h0, "block released start");
    repeat (4) tick();
    chk(op_cnt_o[K_BLOCKED] === 16'h0002, "blocked count");
    // Second reset in mid-run
    @(posedge clk_sys_i);
    rst_n_i <= 1'h0;
    repeat (2) tick();
    rst_chk();
    @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (2) tick();
    chk(blocked_o === 1'h1 && start_o === 1'h0, "reset blocked");
    close_out();
  end
endmodule // tb
`default_nettype wire

// file: inc/brk_fail_pkg.sv
// Shared types and constants for the breaker-failure supervision logic
package brk_fail_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned HZ_PER_MHZ   = 1_000_000;
  localparam int unsigned STEP_US      = 5000;     // Delay step, 0.005 s
  localparam int unsigned STEP_CYC_DEF = STEP_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned PRE_W        = 20;

  // ---------------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------------
  localparam int unsigned DLY_W     = 19;  // Up to 1800 s in 5 ms steps
  localparam int unsigned CUR_W     = 16;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned TS_W      = 32;
  localparam int unsigned GRP_W     = 3;
  localparam int unsigned LOG_DEPTH = 12;
  localparam int unsigned LOG_IDX_W = 4;
  localparam int unsigned NUM_COND  = 8;
  localparam int unsigned NUM_OPCNT = 4;

  // Default delays in steps: 0.100 s and 0.200 s
  localparam logic [DLY_W-1:0] RETRIP_DLY_DEF = 19'h00014;
  localparam logic [DLY_W-1:0] FAIL_DLY_DEF   = 19'h00028;
  localparam logic [DLY_W-1:0] DLY_MAX        = 19'h7FFFF;
  localparam logic [LOG_IDX_W-1:0] LOG_LAST   = 4'hB;

  // Bit positions of the event condition vector
  localparam int unsigned C_START   = 0;
  localparam int unsigned C_RETRIP  = 1;
  localparam int unsigned C_FAIL    = 2;
  localparam int unsigned C_BLOCK   = 3;
  localparam int unsigned C_OUTMON  = 4;
  localparam int unsigned C_SIGNAL  = 5;
  localparam int unsigned C_PHASE   = 6;
  localparam int unsigned C_RES     = 7;

  // Bit positions of the operation counters
  localparam int unsigned K_RETRIP  = 0;
  localparam int unsigned K_FAIL    = 1;
  localparam int unsigned K_START   = 2;
  localparam int unsigned K_BLOCKED = 3;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRIT_CURRENT, CRIT_CUR_AND_OUT, CRIT_CUR_OR_OUT, CRIT_INPUT
  } crit_mode_t;

  typedef enum logic [1:0] {
    SEL_ON, SEL_OFF, SEL_BOTH, SEL_BOTH_ALT
  } ev_sel_t;

  typedef enum logic [1:0] {
    LOG_START, LOG_RETRIP, LOG_FAIL, LOG_BLOCKED
  } log_ev_t;

  typedef struct packed {
    logic [CUR_W-1:0] ph_a;
    logic [CUR_W-1:0] ph_b;
    logic [CUR_W-1:0] ph_c;
    logic [CUR_W-1:0] res;
  } meas_t;

  typedef struct packed {
    crit_mode_t       mode;
    logic             retrip_en;
    logic             in_cur_mon;
    logic             in_out_mon;
    logic [DLY_W-1:0] retrip_dly;
    logic [DLY_W-1:0] fail_dly;
    ev_sel_t          ev_sel;
  } cfg_t;

  typedef struct packed {
    logic [NUM_COND-1:0] on;
    logic [NUM_COND-1:0] off;
    logic [TS_W-1:0]     stamp;
  } event_t;

  typedef struct packed {
    logic [TS_W-1:0]  stamp;
    log_ev_t          ev;
    logic [CUR_W-1:0] max_ph;
    logic [CUR_W-1:0] res;
    logic [GRP_W-1:0] group;
    logic [DLY_W-1:0] retrip_left;
    logic [DLY_W-1:0] fail_left;
  } log_rec_t;

endpackage

// file: rtl/brk_fail_log.sv
// Twelve-entry ring of operation records with oldest-first readout
`timescale 1ns/1ns
`default_nettype none
module brk_fail_log (
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             ce_i,
  input  wire logic                             wr_i,
  input  wire brk_fail_pkg::log_rec_t           rec_i,
  input  wire logic [brk_fail_pkg::LOG_IDX_W-1:0] rd_idx_i,
  output var        brk_fail_pkg::log_rec_t     rd_rec_o,
  output logic [brk_fail_pkg::LOG_IDX_W-1:0]    count_o
);
  import brk_fail_pkg::*;

  log_rec_t             mem_ff [LOG_DEPTH];
  log_rec_t             nxt_mem [LOG_DEPTH];
  logic [LOG_IDX_W-1:0] wp_ff;
  logic [LOG_IDX_W-1:0] nxt_wp;
  logic [LOG_IDX_W-1:0] nxt_count;
  log_rec_t             nxt_rd;

  // Wrap an index that may run one lap past the end
  function automatic logic [LOG_IDX_W-1:0] wrap(
    input logic [LOG_IDX_W:0] idx
  );
    if (idx > {1'b0, LOG_LAST}) begin
      wrap = LOG_IDX_W'(idx - LOG_DEPTH);
    end else begin
      wrap = idx[LOG_IDX_W-1:0];
    end
  endfunction

  // ---------------------------------------------------------------------
  // Write side and readout
  // ---------------------------------------------------------------------
  // Oldest record is overwritten once the ring is full
  always_comb begin
    nxt_mem   = mem_ff;
    nxt_wp    = wp_ff;
    nxt_count = count_o;
    if (wr_i) begin
      nxt_mem[wp_ff] = rec_i;                      // R16
      nxt_wp         = wrap({1'b0, wp_ff} + 5'h01); // R22
      if (count_o != LOG_IDX_W'(LOG_DEPTH)) begin
        nxt_count = count_o + 4'h1;
      end
    end
    // Index 0 is the oldest record held
    if (count_o == LOG_IDX_W'(LOG_DEPTH)) begin
      nxt_rd = mem_ff[wrap({1'b0, wp_ff} + {1'b0, rd_idx_i})]; // R22
    end else begin
      nxt_rd = mem_ff[wrap({1'b0, rd_idx_i})];
    end
  end

  // Registers of the ring
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wp_ff    <= '0;
      count_o  <= '0;
      rd_rec_o <= '0;
      for (int i = 0; i < LOG_DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (ce_i) begin
      wp_ff    <= nxt_wp;
      count_o  <= nxt_count;
      rd_rec_o <= nxt_rd;
      mem_ff   <= nxt_mem;
    end
  end

endmodule // brk_fail_log
`default_nettype wire

// file: rtl/brk_fail_timer.sv
// Breaker-failure supervision: pick-up, delay timers, events, counters
//
// Notes on behaviour
// R01: Current mode: phase or residual over threshold starts the timer.
// R02: Current mode: primary trip output plays no part.
// R03: Current mode: timer clears when currents drop; expiry raises fail.
// R04: And mode: timer held at zero until the trip output is active.
// R05: And mode: timing runs while trip and current pick-up both hold.
// R06: And mode: timer clears when current drops or trip releases.
// R07: Or mode: current or trip output starts the timer.
// R08: Or mode: trip watched always; either keeps pick-up active.
// R09: Or mode: clears only with current low and trip released.
// R10: Input mode: pick-up from digital input, optionally gated by monitors.
// R11: Input mode: input starts timer; held to expiry raises fail.
// R12: Input mode still drives retrip and fail with own delays.
// R13: ON and OFF events from eight condition changes.
// R14: Event filter passes ON, OFF or both, with time stamp.
// R15: Four resettable counters: retrip, fail, start, blocked.
// R16: Log keeps the twelve latest time-stamped records.
// R17: Record holds stamp, event, max phase, residual, group.
// R18: Record holds remaining retrip and fail time.
// R19: Fail output after fail delay, 5 ms steps, default 200 ms.
// R20: Retrip output after retrip delay when enabled, default 100 ms.
// R21: Block at pick-up gives blocked, no timing; block releases start.
// R22: Full log overwrites oldest; readout stays in time order.
`timescale 1ns/1ns
`default_nettype none
module brk_fail_timer #(
  parameter int unsigned STEP_CYCLES = brk_fail_pkg::STEP_CYC_DEF
) (
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               ce_i,
  input  wire brk_fail_pkg::meas_t                meas_i,
  input  wire logic [brk_fail_pkg::CUR_W-1:0]     ph_set_i,
  input  wire logic [brk_fail_pkg::CUR_W-1:0]     res_set_i,
  input  wire logic                               trip_mon_i,
  input  wire logic                               dig_in_i,
  input  wire logic                               block_i,
  input  wire brk_fail_pkg::cfg_t                 cfg_i,
  input  wire logic [brk_fail_pkg::GRP_W-1:0]     group_i,
  input  wire logic [brk_fail_pkg::TS_W-1:0]      stamp_i,
  input  wire logic [brk_fail_pkg::NUM_OPCNT-1:0] cnt_clr_i,
  input  wire logic [brk_fail_pkg::LOG_IDX_W-1:0] log_idx_i,
  output logic                                    start_o,
  output logic                                    retrip_o,
  output logic                                    breaker_fail_output_o,
  output logic                                    blocked_o,
  output logic [brk_fail_pkg::DLY_W-1:0]          retrip_time_remaining_o,
  output logic [brk_fail_pkg::DLY_W-1:0]          fail_time_remaining_o,
  output var        brk_fail_pkg::event_t         event_o,
  output logic [brk_fail_pkg::NUM_OPCNT-1:0][brk_fail_pkg::CNT_W-1:0]
                                                  op_cnt_o,
  output var        brk_fail_pkg::log_rec_t       log_rec_o,
  output logic [brk_fail_pkg::LOG_IDX_W-1:0]      log_count_o
);
  import brk_fail_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_TIMING, ST_BLOCKED} tmr_state_t;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Largest of the three phase currents
  function automatic logic [CUR_W-1:0] max3(input meas_t m);
    logic [CUR_W-1:0] ab;
    ab   = (m.ph_a > m.ph_b) ? m.ph_a : m.ph_b;
    max3 = (ab > m.ph_c) ? ab : m.ph_c;
  endfunction

  // Time left until a delay expires, floored at zero
  function automatic logic [DLY_W-1:0] left(
    input logic [DLY_W-1:0] dly,
    input logic [DLY_W-1:0] el
  );
    left = (dly > el) ? (dly - el) : '0;
  endfunction

  // ---------------------------------------------------------------------
  // Pick-up criterion
  // ---------------------------------------------------------------------
  logic ph_over;
  logic res_over;
  logic cur_pick;
  logic pick;

  // Threshold comparison and mode selection
  always_comb begin
    ph_over  = (max3(meas_i) > ph_set_i);
    res_over = (meas_i.res > res_set_i);
    cur_pick = ph_over | res_over;                  // R01
    unique case (cfg_i.mode)
      CRIT_CURRENT:     pick = cur_pick;            // R02
      CRIT_CUR_AND_OUT: pick = cur_pick & trip_mon_i; // R04 R05 R06
      CRIT_CUR_OR_OUT:  pick = cur_pick | trip_mon_i; // R07 R08 R09
      CRIT_INPUT: begin
        // Monitors optionally qualify the digital input
        pick = dig_in_i                             // R10 R11
             & (cur_pick   | ~cfg_i.in_cur_mon)
             & (trip_mon_i | ~cfg_i.in_out_mon);
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Timer state and step prescaler
  // ---------------------------------------------------------------------
  tmr_state_t       st_ff;
  tmr_state_t       nxt_st;
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [DLY_W-1:0] el_ff;
  logic [DLY_W-1:0] nxt_el;

  // Start, block and release decisions
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (pick && block_i) begin
          nxt_st = ST_BLOCKED;                      // R21
        end else if (pick) begin
          nxt_st = ST_TIMING;
        end
      end
      ST_TIMING: begin
        if (!pick || block_i) begin
          nxt_st = ST_IDLE;                         // R03 R06 R09 R21
        end
      end
      ST_BLOCKED: begin
        if (!pick) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Elapsed time in 5 ms steps, cleared at once when not timing
  always_comb begin
    nxt_pre = '0;
    nxt_el  = '0;                                   // R03 R04 R06 R09
    if (nxt_st == ST_TIMING && st_ff == ST_TIMING) begin
      nxt_el = el_ff;
      if (pre_ff == PRE_LAST) begin
        if (el_ff != DLY_MAX) begin
          nxt_el = el_ff + 19'h00001;               // R19
        end
      end else begin
        nxt_pre = pre_ff + 20'h00001;
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_ff  <= ST_IDLE;
      pre_ff <= '0;
      el_ff  <= '0;
    end else if (ce_i) begin
      st_ff  <= nxt_st;
      pre_ff <= nxt_pre;
      el_ff  <= nxt_el;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs of the timer
  // ---------------------------------------------------------------------
  logic             timing;
  logic             nxt_start;
  logic             nxt_retrip;
  logic             nxt_fail;
  logic             nxt_blocked;
  logic [DLY_W-1:0] nxt_rt_left;
  logic [DLY_W-1:0] nxt_fl_left;

  // Expiry compares; both timers share the one pick-up
  always_comb begin
    timing      = (st_ff == ST_TIMING);
    nxt_start   = timing;
    nxt_blocked = (st_ff == ST_BLOCKED);            // R21
    nxt_retrip  = timing & cfg_i.retrip_en
                & (el_ff >= cfg_i.retrip_dly);      // R20 R12
    nxt_fail    = timing & (el_ff >= cfg_i.fail_dly); // R19 R03 R11 R12
    nxt_rt_left = left(cfg_i.retrip_dly, el_ff);
    nxt_fl_left = left(cfg_i.fail_dly, el_ff);
  end

  // Output registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_o                 <= 1'b0;
      retrip_o                <= 1'b0;
      breaker_fail_output_o   <= 1'b0;
      blocked_o               <= 1'b0;
      retrip_time_remaining_o <= RETRIP_DLY_DEF;
      fail_time_remaining_o   <= FAIL_DLY_DEF;
    end else if (ce_i) begin
      start_o                 <= nxt_start;
      retrip_o                <= nxt_retrip;
      breaker_fail_output_o   <= nxt_fail;
      blocked_o               <= nxt_blocked;
      retrip_time_remaining_o <= nxt_rt_left;
      fail_time_remaining_o   <= nxt_fl_left;
    end
  end

  // ---------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------
  logic [NUM_COND-1:0] cond;
  logic [NUM_COND-1:0] cond_ff;
  logic [NUM_COND-1:0] rise;
  logic [NUM_COND-1:0] fall;
  event_t              nxt_event;

  // Edge detection and ON/OFF filtering
  always_comb begin
    cond           = '0;
    cond[C_START]  = start_o;                       // R13
    cond[C_RETRIP] = retrip_o;
    cond[C_FAIL]   = breaker_fail_output_o;
    cond[C_BLOCK]  = block_i;
    cond[C_OUTMON] = trip_mon_i;
    cond[C_SIGNAL] = dig_in_i;
    cond[C_PHASE]  = ph_over;
    cond[C_RES]    = res_over;
    rise           = cond & ~cond_ff;
    fall           = ~cond & cond_ff;
    nxt_event.on   = (cfg_i.ev_sel != SEL_OFF) ? rise : '0; // R14
    nxt_event.off  = (cfg_i.ev_sel != SEL_ON) ? fall : '0;  // R14
    nxt_event.stamp = stamp_i;                      // R14
  end

  // Event registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cond_ff <= '0;
      event_o <= '0;
    end else if (ce_i) begin
      cond_ff <= cond;
      event_o <= nxt_event;
    end
  end

  // ---------------------------------------------------------------------
  // Cumulative operation counters
  // ---------------------------------------------------------------------
  logic [NUM_OPCNT-1:0] op_hit;
  logic                 blk_ff;
  logic                 nxt_blk;

  // Rising edges of the counted operations
  always_comb begin
    nxt_blk            = blocked_o;
    op_hit             = '0;
    op_hit[K_RETRIP]   = rise[C_RETRIP];            // R15
    op_hit[K_FAIL]     = rise[C_FAIL];
    op_hit[K_START]    = rise[C_START];
    op_hit[K_BLOCKED]  = blocked_o & ~blk_ff;
  end

  // Edge memory for the blocked indication
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      blk_ff <= 1'b0;
    end else if (ce_i) begin
      blk_ff <= nxt_blk;
    end
  end

  // One counter each; a hit in the clear cycle is kept
  for (genvar k = 0; k < NUM_OPCNT; k++) begin : g_opcnt
    logic [CNT_W-1:0] nxt_cnt;

    // Clear, then count; saturates at all ones
    always_comb begin
      nxt_cnt = cnt_clr_i[k] ? '0 : op_cnt_o[k];    // R15
      if (op_hit[k] && nxt_cnt != '1) begin
        nxt_cnt = nxt_cnt + 16'h0001;
      end
    end

    // Counter register
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        op_cnt_o[k] <= '0;
      end else if (ce_i) begin
        op_cnt_o[k] <= nxt_cnt;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Operation log
  // ---------------------------------------------------------------------
  logic     log_wr;
  log_rec_t log_rec;

  // One record per cycle; fail outranks retrip, blocked and start
  always_comb begin
    log_wr = op_hit[K_FAIL] | op_hit[K_RETRIP]
           | op_hit[K_BLOCKED] | op_hit[K_START];
    if (op_hit[K_FAIL]) begin
      log_rec.ev = LOG_FAIL;
    end else if (op_hit[K_RETRIP]) begin
      log_rec.ev = LOG_RETRIP;
    end else if (op_hit[K_BLOCKED]) begin
      log_rec.ev = LOG_BLOCKED;
    end else begin
      log_rec.ev = LOG_START;
    end
    log_rec.stamp       = stamp_i;                  // R17
    log_rec.max_ph      = max3(meas_i);             // R17
    log_rec.res         = meas_i.res;               // R17
    log_rec.group       = group_i;                  // R17
    log_rec.retrip_left = retrip_time_remaining_o;  // R18
    log_rec.fail_left   = fail_time_remaining_o;    // R18
  end

  // Record ring
  brk_fail_log u_log (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .wr_i      (log_wr),                            // R16
    .rec_i     (log_rec),
    .rd_idx_i  (log_idx_i),
    .rd_rec_o  (log_rec_o),
    .count_o   (log_count_o)
  );

endmodule // brk_fail_timer
`default_nettype wire
